// File: common/cap_pkg.sv
// Package for the acknowledged change-of-state producer state machine
package cap_pkg;

  typedef enum logic [3:0] {
    CAP_IDLE  = 4'h1,
    CAP_RUN   = 4'h2,
    CAP_RACK  = 4'h4,
    CAP_PROH  = 4'h8
  } cap_state_t;

  localparam logic [3:0] CAP_RST_STATE = 4'h1;
  localparam logic       CAP_RST_FLAG  = 1'b0;
  localparam int         CAP_INH_W     = 16;
  localparam logic [15:0] CAP_INH_ZERO = 16'h0000;

endpackage : cap_pkg

// File: verilog/cap_inhibit_timer.sv
// Inhibit interval down-counter with one-cycle expiry pulse
`timescale 1ns/10ps
module cap_inhibit_timer
  import cap_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_start,
  input  wire logic                 i_stop,
  input  wire logic [CAP_INH_W-1:0] i_load,
  output logic                      o_running,
  output logic                      o_expire
);

  logic [CAP_INH_W-1:0] cnt_q;
  logic [CAP_INH_W-1:0] cnt_d;
  logic                 exp_q;
  logic                 exp_d;

  always_comb
  begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (i_stop)
    begin
      cnt_d = CAP_INH_ZERO;
    end
    else if (i_start)
    begin
      cnt_d = i_load;
    end
    else if (cnt_q != CAP_INH_ZERO)
    begin
      cnt_d = cnt_q - 16'h0001;
      exp_d = (cnt_q == 16'h0001);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cnt_q <= CAP_INH_ZERO;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign o_running = (cnt_q != CAP_INH_ZERO);
  assign o_expire  = exp_q;

endmodule : cap_inhibit_timer

// File: verilog/cap_producer_fsm.sv
// Acknowledged change-of-state producer state machine
// Notes on behaviour
// - A state change is ignored when idle, queued when prohibited, and when running sends data and may enter prohibited with the inhibit timer started.
// - A state change in running-with-ack sends data, gives a fresh-send notice, and may enter prohibited with the inhibit timer started.
// - An ack in prohibited with ack mode set enters running-with-ack if the inhibit timer is idle, else sets the ack-arrived flag.
// - An ack timeout in running-with-ack or prohibited resends data with a repeat-send notice and no state change.
// - Transmission timer expiry in running sends data only.
// - Transmission timer expiry in running-with-ack sends data with a fresh-send notice.
// - Transmission timer expiry in prohibited resends the last data with a fresh-send notice.
// - Retry limit in prohibited enters running-with-ack; in running-with-ack it moves to running only if configured to.
// - Inhibit expiry in prohibited enters running with ack mode clear, or running-with-ack clearing ack-arrived when that is set.
// - Connection established while idle enters running-with-ack if ack mode is set, else running.
// - Ack-activate sets ack mode everywhere and moves running to running-with-ack.
// - Ack-deactivate clears ack mode everywhere and moves running-with-ack to running.
`timescale 1ns/10ps
module cap_producer_fsm
  import cap_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_cos_detect,
  input  wire logic                 i_ack_rx,
  input  wire logic                 i_ack_timeout,
  input  wire logic                 i_tx_timer_exp,
  input  wire logic                 i_retry_limit,
  input  wire logic                 i_conn_delete,
  input  wire logic                 i_conn_estab,
  input  wire logic                 i_ack_activate,
  input  wire logic                 i_ack_deactivate,
  input  wire logic [CAP_INH_W-1:0] i_inhibit_time,
  input  wire logic                 i_retry_to_run,
  output logic                      o_send_new,
  output logic                      o_send_last,
  output logic                      o_note_sent,
  output logic                      o_note_resent,
  output logic [3:0]                o_state,
  output logic                      o_ack_mode,
  output logic                      o_ack_arrived,
  output logic                      o_cos_queued
);

  cap_state_t state_q;
  cap_state_t state_d;
  logic       mode_q;
  logic       mode_d;
  logic       arr_q;
  logic       arr_d;
  logic       que_q;
  logic       que_d;
  logic       new_q;
  logic       new_d;
  logic       last_q;
  logic       last_d;
  logic       sent_q;
  logic       sent_d;
  logic       rsnt_q;
  logic       rsnt_d;
  logic       inh_start;
  logic       inh_run;
  logic       inh_exp;
  logic       inh_cfg;
  logic       cos_now;

  assign inh_cfg = (i_inhibit_time != CAP_INH_ZERO);

  cap_inhibit_timer u_inh (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_start    (inh_start),
    .i_stop     (i_conn_delete),
    .i_load     (i_inhibit_time),
    .o_running  (inh_run),
    .o_expire   (inh_exp)
  );

  // Priority: deletion, then a state change entering prohibited, then mode events, in one pass
  always_comb
  begin
    state_d   = state_q;
    mode_d    = mode_q;
    arr_d     = arr_q;
    que_d     = que_q;
    new_d     = 1'b0;
    last_d    = 1'b0;
    sent_d    = 1'b0;
    rsnt_d    = 1'b0;
    inh_start = 1'b0;
    cos_now   = i_cos_detect;
    if (i_ack_activate)
    begin
      mode_d = 1'b1;
    end
    else if (i_ack_deactivate)
    begin
      mode_d = 1'b0;
    end
    // Deletion beats every event, idle included, so no stale flag survives
    if (i_conn_delete)
    begin
      state_d = CAP_IDLE;
      que_d   = 1'b0;
      arr_d   = 1'b0;
      mode_d  = 1'b0;
    end
    else
    begin
      unique case (state_q)
        CAP_IDLE:
        begin
          if (i_conn_estab)
          begin
            state_d = mode_d ? CAP_RACK : CAP_RUN;
          end
        end
        CAP_RUN:
        begin
          if (i_ack_activate)
          begin
            state_d = CAP_RACK;
          end
          if (cos_now)
          begin
            new_d = 1'b1;
            if (inh_cfg)
            begin
              inh_start = 1'b1;
              state_d   = CAP_PROH;
            end
          end
          else if (i_tx_timer_exp)
          begin
            new_d = 1'b1;
          end
        end
        CAP_RACK:
        begin
          if (i_ack_deactivate)
          begin
            state_d = CAP_RUN;
          end
          else if (i_retry_limit && i_retry_to_run)
          begin
            state_d = CAP_RUN;
          end
          if (cos_now)
          begin
            new_d  = 1'b1;
            sent_d = 1'b1;
            if (inh_cfg)
            begin
              inh_start = 1'b1;
              state_d   = CAP_PROH;
            end
          end
          else if (i_tx_timer_exp)
          begin
            new_d  = 1'b1;
            sent_d = 1'b1;
          end
          else if (i_ack_timeout)
          begin
            last_d = 1'b1;
            rsnt_d = 1'b1;
          end
        end
        CAP_PROH:
        begin
          if (cos_now)
          begin
            que_d = 1'b1;
          end
          if (i_tx_timer_exp)
          begin
            last_d = 1'b1;
            sent_d = 1'b1;
          end
          else if (i_ack_timeout)
          begin
            last_d = 1'b1;
            rsnt_d = 1'b1;
          end
          if (i_retry_limit)
          begin
            state_d = CAP_RACK;
          end
          else if (inh_exp)
          begin
            if (!mode_q)
            begin
              state_d = CAP_RUN;
            end
            // Ack landing with expiry counts; timer is already idle then
            else if (arr_q || i_ack_rx)
            begin
              state_d = CAP_RACK;
              arr_d   = 1'b0;
            end
          end
          else if (i_ack_rx && mode_q)
          begin
            if (!inh_run)
            begin
              state_d = CAP_RACK;
            end
            else
            begin
              arr_d = 1'b1;
            end
          end
        end
        default:
        begin
          state_d = CAP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_q <= cap_state_t'(CAP_RST_STATE);
      mode_q  <= CAP_RST_FLAG;
      arr_q   <= CAP_RST_FLAG;
      que_q   <= CAP_RST_FLAG;
      new_q   <= 1'b0;
      last_q  <= 1'b0;
      sent_q  <= 1'b0;
      rsnt_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mode_q  <= mode_d;
      arr_q   <= arr_d;
      que_q   <= que_d;
      new_q   <= new_d;
      last_q  <= last_d;
      sent_q  <= sent_d;
      rsnt_q  <= rsnt_d;
    end
  end

  assign o_send_new    = new_q;
  assign o_send_last   = last_q;
  assign o_note_sent   = sent_q;
  assign o_note_resent = rsnt_q;
  assign o_state       = state_q;
  assign o_ack_mode    = mode_q;
  assign o_ack_arrived = arr_q;
  assign o_cos_queued  = que_q;

endmodule : cap_producer_fsm

// File: tb/cap_monitor.sv
// Checker bound to the producer state machine
`timescale 1ns/10ps
module cap_monitor
(
  input wire logic       i_core_clk,
  input wire logic       i_srst,
  input wire logic       i_cos_detect,
  input wire logic       i_ack_timeout,
  input wire logic       i_tx_timer_exp,
  input wire logic       i_retry_limit,
  input wire logic       i_conn_delete,
  input wire logic       i_conn_estab,
  input wire logic       i_ack_activate,
  input wire logic       i_ack_deactivate,
  input wire logic       o_send_new,
  input wire logic       o_send_last,
  input wire logic       o_note_sent,
  input wire logic       o_note_resent,
  input wire logic [3:0] o_state,
  input wire logic       o_ack_mode,
  input wire logic       o_ack_arrived,
  input wire logic       o_cos_queued
);
  logic [3:0] st;
  logic       nd;
  assign st = o_state;
  // Deletion wins over every other event
  assign nd = !i_conn_delete;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_idle_cos_quiet: assert property (
    st == 4'h1 && i_cos_detect |=> !o_send_new && !o_note_sent)
    else $error("send while idle");
  a_rack_cos_note: assert property (
    st == 4'h4 && i_cos_detect && nd |=> o_send_new && o_note_sent)
    else $error("no fresh send");
  a_timeout_resend: assert property (
    st[3:2] != 2'h0 && i_ack_timeout && nd && !i_cos_detect
    && !i_tx_timer_exp |=> o_send_last && o_note_resent)
    else $error("no resend");
  a_proh_tx_last: assert property (
    st == 4'h8 && i_tx_timer_exp && nd
    |=> o_send_last && o_note_sent && !o_send_new)
    else $error("bad prohibited send");
  a_proh_retry_rack: assert property (
    st == 4'h8 && i_retry_limit && nd |=> st == 4'h4)
    else $error("retry not taken");
  a_delete_clears: assert property (
    i_conn_delete |-> ##1 st == 4'h1 && !o_ack_mode && !o_ack_arrived
    && !o_cos_queued)
    else $error("delete incomplete");
  a_estab_mode: assert property (
    st == 4'h1 && i_conn_estab && nd && !i_ack_activate
    && !i_ack_deactivate |=> st == (o_ack_mode ? 4'h4 : 4'h2))
    else $error("bad establish");
  a_deact_to_run: assert property (
    st == 4'h4 && i_ack_deactivate && nd && !i_ack_activate
    && !i_cos_detect |=> st == 4'h2 && !o_ack_mode)
    else $error("bad deactivate");
endmodule : cap_monitor

bind cap_producer_fsm cap_monitor cap_monitor_inst (
  .i_core_clk       (i_core_clk),
  .i_srst           (i_srst),
  .i_cos_detect     (i_cos_detect),
  .i_ack_timeout    (i_ack_timeout),
  .i_tx_timer_exp   (i_tx_timer_exp),
  .i_retry_limit    (i_retry_limit),
  .i_conn_delete    (i_conn_delete),
  .i_conn_estab     (i_conn_estab),
  .i_ack_activate   (i_ack_activate),
  .i_ack_deactivate (i_ack_deactivate),
  .o_send_new       (o_send_new),
  .o_send_last      (o_send_last),
  .o_note_sent      (o_note_sent),
  .o_note_resent    (o_note_resent),
  .o_state          (o_state),
  .o_ack_mode       (o_ack_mode),
  .o_ack_arrived    (o_ack_arrived),
  .o_cos_queued     (o_cos_queued)
);

// File: tb/cap_ack_partner.sv
// Far-side model answering each send notice with an acknowledge
`timescale 1ns/10ps
module cap_ack_partner
#(
  parameter int DLY = 2
)
(
  input  wire logic i_core_clk,
  input  wire logic i_arm,
  input  wire logic i_note,
  output logic      o_ack
);
  int cnt = -1;
  initial o_ack = 1'b0;
  // Slow answer lets the ack land while the inhibit timer runs
  always @(posedge i_core_clk)
  begin
    o_ack <= #1 i_arm && cnt == 0;
    if (!i_arm || cnt == 0)
      cnt = -1;
    else if (i_note)
      cnt = DLY;
    else if (cnt > 0)
      cnt--;
  end
endmodule : cap_ack_partner

// File: tb/testbench.sv
// Self-checking bench for the producer state machine
`timescale 1ns/10ps
module testbench;
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [8:0]  ev = 9'h000;
  logic [15:0] i_inhibit_time = 16'h0000;
  logic        i_retry_to_run = 1'b0;
  logic        arm = 1'b0;
  logic        i_cos_detect, b_ack, p_ack, i_ack_rx, i_ack_timeout;
  logic        i_tx_timer_exp, i_retry_limit, i_conn_delete, i_conn_estab;
  logic        i_ack_activate, i_ack_deactivate, o_send_new, o_send_last;
  logic        o_note_sent, o_note_resent, o_ack_mode, o_ack_arrived;
  logic        o_cos_queued;
  logic [3:0]  o_state;
  logic [31:0] rnd = 32'h270f;
  logic [10:0] q[$];
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          r;
  int          k;
  always #2.5 i_core_clk = ~i_core_clk;
  assign {i_cos_detect, b_ack, i_ack_timeout, i_tx_timer_exp, i_retry_limit,
    i_conn_delete, i_conn_estab, i_ack_activate, i_ack_deactivate} = ev;
  assign i_ack_rx = b_ack | p_ack;
  cap_producer_fsm cap_producer_fsm_inst (
    .i_core_clk       (i_core_clk),
    .i_srst           (i_srst),
    .i_cos_detect     (i_cos_detect),
    .i_ack_rx         (i_ack_rx),
    .i_ack_timeout    (i_ack_timeout),
    .i_tx_timer_exp   (i_tx_timer_exp),
    .i_retry_limit    (i_retry_limit),
    .i_conn_delete    (i_conn_delete),
    .i_conn_estab     (i_conn_estab),
    .i_ack_activate   (i_ack_activate),
    .i_ack_deactivate (i_ack_deactivate),
    .i_inhibit_time   (i_inhibit_time),
    .i_retry_to_run   (i_retry_to_run),
    .o_send_new       (o_send_new),
    .o_send_last      (o_send_last),
    .o_note_sent      (o_note_sent),
    .o_note_resent    (o_note_resent),
    .o_state          (o_state),
    .o_ack_mode       (o_ack_mode),
    .o_ack_arrived    (o_ack_arrived),
    .o_cos_queued     (o_cos_queued)
  );
  cap_ack_partner cap_ack_partner_inst (.i_core_clk(i_core_clk),
    .i_arm(arm), .i_note(o_note_sent | o_note_resent), .o_ack(p_ack));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Note is {state, new, last, sent, resent, mode, arrived, queued}
  task automatic step(input logic [8:0] e, input logic [10:0] x);
    #1 ev = e;
    @(posedge i_core_clk);
    q.push_back(x);
  endtask : step
  task automatic wait_state(input logic [3:0] s);
    // Drop the last event so it does not fire again while waiting
    #1 ev = 9'h000;
    k = 0;
    do
    begin
      @(negedge i_core_clk);
      k++;
    end while (o_state !== s && k < 40);
    @(posedge i_core_clk);
  endtask : wait_state
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  always @(negedge i_core_clk)
    if (q.size() > 0)
      chk({o_state, o_send_new, o_send_last, o_note_sent, o_note_resent,
        o_ack_mode, o_ack_arrived, o_cos_queued}, q.pop_front());
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      end_sim();
    end
  end
  initial
  begin
    repeat (8) @(posedge i_core_clk);
    i_srst <= 1'b0;
    step(9'h100, 11'h080);
    step(9'h040, 11'h080);
    step(9'h010, 11'h080);
    step(9'h004, 11'h100);
    step(9'h020, 11'h140);
    step(9'h100, 11'h140);
    step(9'h002, 11'h204);
    step(9'h020, 11'h254);
    step(9'h100, 11'h254);
    step(9'h040, 11'h22c);
    step(9'h080, 11'h204);
    step(9'h010, 11'h204);
    step(9'h001, 11'h100);
    step(9'h001, 11'h100);
    step(9'h002, 11'h204);
    i_inhibit_time <= 16'h0028;
    step(9'h100, 11'h454);
    step(9'h100, 11'h405);
    step(9'h020, 11'h435);
    step(9'h040, 11'h42d);
    step(9'h080, 11'h407);
    step(9'h008, 11'h080);
    step(9'h004, 11'h100);
    step(9'h002, 11'h204);
    step(9'h100, 11'h454);
    step(9'h010, 11'h204);
    repeat (45) step(9'h000, 11'h204);
    i_retry_to_run <= 1'b1;
    step(9'h010, 11'h104);
    step(9'h001, 11'h100);
    rnd = lfsr(rnd);
    r = 2 + int'(rnd[1:0]);
    i_inhibit_time <= 16'(r);
    step(9'h100, 11'h440);
    wait_state(4'h2);
    chk(11'(k >= r && k <= r + 2), 11'h001);
    step(9'h002, 11'h204);
    arm <= 1'b1;
    i_inhibit_time <= 16'h0014;
    step(9'h100, 11'h454);
    #1 ev = 9'h000;
    repeat (7) @(negedge i_core_clk);
    chk(11'({o_state, o_ack_arrived}), 11'h011);
    wait_state(4'h4);
    chk(11'({o_state, o_ack_arrived}), 11'h008);
    arm <= 1'b0;
    i_inhibit_time <= 16'h0003;
    step(9'h100, 11'h454);
    repeat (8) step(9'h000, 11'h404);
    step(9'h080, 11'h204);
    step(9'h008, 11'h080);
    step(9'h000, 11'h080);
    // Let the watcher take the last note before the verdict
    repeat (2) @(negedge i_core_clk);
    if (q.size() > 0)
      n_fail++;
    end_sim();
  end
endmodule : testbench
